// ### dsof_pkg.sv
/*
 * Constants for the drive status output flag block: register map,
 * field layout, reset values and option codes.
 * Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
 */
package dsof_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [4:0] ADDR_OVERLOAD_LEVEL = 5'h00;
    localparam logic [4:0] ADDR_DEVIATION_LEVEL = 5'h04;
    localparam logic [4:0] ADDR_SEL_OUT11 = 5'h08;
    localparam logic [4:0] ADDR_SEL_OUT12 = 5'h0C;
    localparam logic [4:0] ADDR_SEL_RELAY = 5'h10;
    localparam logic [4:0] ADDR_FLAG_STATE = 5'h14;
    localparam logic [4:0] ADDR_IRQ_STATUS = 5'h18;
    localparam logic [4:0] ADDR_IRQ_MASK = 5'h1C;

    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam int LEVEL_W = 16;
    localparam int SEL_W = 8;
    localparam int NUM_FLAGS = 3;
    localparam int BIT_OVERLOAD = 0;
    localparam int BIT_DEVIATION = 1;
    localparam int BIT_ALARM = 2;

    // ----------------------------------------------------------------
    // option codes
    // ----------------------------------------------------------------
    typedef enum logic [7:0] {
        DSOF_OPT_OVERLOAD = 8'h03,
        DSOF_OPT_DEVIATION = 8'h04,
        DSOF_OPT_ALARM = 8'h05
    } dsof_option_t;

    // ----------------------------------------------------------------
    // reset values (levels in units of 0.1 %)
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_OVERLOAD_LEVEL = 16'h03E8;
    localparam logic [15:0] RST_DEVIATION_LEVEL = 16'h001E;
    localparam logic [7:0] RST_SEL_OUT11 = 8'h03;
    localparam logic [7:0] RST_SEL_OUT12 = 8'h04;
    localparam logic [7:0] RST_SEL_RELAY = 8'h05;
    localparam logic [2:0] RST_IRQ_MASK = 3'h0;

endpackage

// ### dsof_flags.sv
/*
 * Status flag logic for the drive's programmable output terminals:
 * overload notice, loop deviation and fault alarm, routed by option codes
 * to two open-collector outputs and the alarm relay; Avalon-MM registers.
 * Assumes all inputs synchronous to clk_sys; quantities in units of 0.1 %.
 */
// Register access over Avalon-MM and the address map were decided locally.
// Function
// (R01) With option 03 selected, the overload flag is set when output current exceeds its level.
// (R02) The overload flag clears when output current is below its level.
// (R03) The overload compare runs in both motoring and regenerative braking, never gated.
// (R04) Each open-collector terminal is active low, pulled low while its flag is set.
// (R05) The overload level resets to 100 % of rated current until software writes it.
// (R06) Loop error is the absolute value of setpoint minus process value.
// (R07) With option 04 selected, the deviation flag is set when loop error exceeds its level.
// (R08) The deviation flag clears when loop error is below its level.
// (R09) The deviation level resets to 3 % until software writes it.
// (R10) The alarm flag is set once a fault has put the drive in its trip state.
// (R11) The alarm flag clears once the fault has been cleared.
// (R12) Any flag may go to either open-collector output or the relay; the relay carries the alarm after reset.
// (R13) A quantity exactly equal to its level leaves the flag unchanged.
// (R14) Each terminal carries exactly the one flag chosen by its option code.
`timescale 1ns/1ns
module dsof_flags #(
    parameter int LEVEL_W = dsof_pkg::LEVEL_W
) (
    input wire logic clk_sys,                       // 10 MHz system clock
    input wire logic rst,                           // synchronous reset, active high
    input wire logic [LEVEL_W-1:0] output_current,  // measured current, 0.1 % of rated
    input wire logic regen_braking,                 // drive absorbing regenerative energy
    input wire logic [LEVEL_W-1:0] loop_setpoint,   // loop target value
    input wire logic [LEVEL_W-1:0] process_value,   // loop measured value
    input wire logic trip_active,                   // drive in trip state
    input wire logic [4:0] avs_address,             // byte address
    input wire logic avs_read,                      // read request
    input wire logic avs_write,                     // write request
    input wire logic [31:0] avs_writedata,          // write data
    input wire logic [3:0] avs_byteenable,          // byte lanes
    output logic [31:0] avs_readdata,               // read data
    output logic avs_waitrequest,                   // stall
    output logic oc_out11_n,                        // open collector 11, low = on
    output logic oc_out12_n,                        // open collector 12, low = on
    output logic relay_coil_on,                     // relay energised
    output logic irq                                // level interrupt
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [LEVEL_W-1:0] overload_level;
    logic [LEVEL_W-1:0] deviation_level;
    logic [7:0] sel_out11;
    logic [7:0] sel_out12;
    logic [7:0] sel_relay;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [2:0] flags;
    logic [2:0] flags_d;
    logic overload_notice_flag;
    logic loop_deviation_flag;
    logic fault_alarm_flag;
    logic [LEVEL_W-1:0] loop_error;
    logic wr_go;
    logic rd_go;
    logic [2:0] rd_snap;
    logic [31:0] next_readdata;

    assign wr_go = avs_write && !avs_waitrequest;
    assign rd_go = avs_read && !avs_waitrequest;

    // ----------------------------------------------------------------
    // bus handshake: one stall cycle, then accept
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_comb begin
        next_readdata = 32'h0000_0000;
        case (avs_address)
            dsof_pkg::ADDR_OVERLOAD_LEVEL: next_readdata[LEVEL_W-1:0] = overload_level;
            dsof_pkg::ADDR_DEVIATION_LEVEL: next_readdata[LEVEL_W-1:0] = deviation_level;
            dsof_pkg::ADDR_SEL_OUT11: next_readdata[7:0] = sel_out11;
            dsof_pkg::ADDR_SEL_OUT12: next_readdata[7:0] = sel_out12;
            dsof_pkg::ADDR_SEL_RELAY: next_readdata[7:0] = sel_relay;
            dsof_pkg::ADDR_FLAG_STATE: next_readdata[2:0] = flags;
            dsof_pkg::ADDR_IRQ_STATUS: next_readdata[2:0] = irq_status;
            dsof_pkg::ADDR_IRQ_MASK: next_readdata[2:0] = irq_mask;
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    // read data latched when the stall drops, held through the accept edge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
            rd_snap <= 3'h0;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= next_readdata;
            rd_snap <= (avs_address == dsof_pkg::ADDR_IRQ_STATUS) ? next_readdata[2:0] : 3'h0;
        end
    end

    // ----------------------------------------------------------------
    // writable registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            overload_level <= LEVEL_W'(dsof_pkg::RST_OVERLOAD_LEVEL); // R05
            deviation_level <= LEVEL_W'(dsof_pkg::RST_DEVIATION_LEVEL); // R09
            sel_out11 <= dsof_pkg::RST_SEL_OUT11;
            sel_out12 <= dsof_pkg::RST_SEL_OUT12;
            sel_relay <= dsof_pkg::RST_SEL_RELAY; // R12
            irq_mask <= dsof_pkg::RST_IRQ_MASK;
        end else if (wr_go) begin
            case (avs_address)
                dsof_pkg::ADDR_OVERLOAD_LEVEL: begin
                    if (avs_byteenable[0]) overload_level[7:0] <= avs_writedata[7:0];
                    if (avs_byteenable[1]) overload_level[15:8] <= avs_writedata[15:8];
                end
                dsof_pkg::ADDR_DEVIATION_LEVEL: begin
                    if (avs_byteenable[0]) deviation_level[7:0] <= avs_writedata[7:0];
                    if (avs_byteenable[1]) deviation_level[15:8] <= avs_writedata[15:8];
                end
                dsof_pkg::ADDR_SEL_OUT11: begin
                    if (avs_byteenable[0]) sel_out11 <= avs_writedata[7:0];
                end
                dsof_pkg::ADDR_SEL_OUT12: begin
                    if (avs_byteenable[0]) sel_out12 <= avs_writedata[7:0];
                end
                dsof_pkg::ADDR_SEL_RELAY: begin
                    if (avs_byteenable[0]) sel_relay <= avs_writedata[7:0];
                end
                dsof_pkg::ADDR_IRQ_MASK: begin
                    if (avs_byteenable[0]) irq_mask <= avs_writedata[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // flag comparators
    // ----------------------------------------------------------------
    assign loop_error = (loop_setpoint >= process_value) ?
        (loop_setpoint - process_value) : (process_value - loop_setpoint); // R06

    // regen_braking deliberately unused in the compare: it must not gate it
    // an equal value takes neither branch, so the flag holds
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            overload_notice_flag <= 1'b0;
        end else if (output_current > overload_level) begin
            overload_notice_flag <= 1'b1; // R01 R03
        end else if (output_current < overload_level) begin
            overload_notice_flag <= 1'b0; // R02 R03
        end // R13
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            loop_deviation_flag <= 1'b0;
        end else if (loop_error > deviation_level) begin
            loop_deviation_flag <= 1'b1; // R07
        end else if (loop_error < deviation_level) begin
            loop_deviation_flag <= 1'b0; // R08
        end // R13
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fault_alarm_flag <= 1'b0;
        end else begin
            fault_alarm_flag <= trip_active; // R10 R11
        end
    end

    // one driver per flag register; the packed view is only a gather
    always_comb begin
        flags = 3'h0;
        flags[dsof_pkg::BIT_OVERLOAD] = overload_notice_flag;
        flags[dsof_pkg::BIT_DEVIATION] = loop_deviation_flag;
        flags[dsof_pkg::BIT_ALARM] = fault_alarm_flag;
    end

    // ----------------------------------------------------------------
    // output routing
    // ----------------------------------------------------------------
    function automatic logic route(input logic [7:0] sel, input logic [2:0] f);
        case (sel)
            dsof_pkg::DSOF_OPT_OVERLOAD: route = f[dsof_pkg::BIT_OVERLOAD];
            dsof_pkg::DSOF_OPT_DEVIATION: route = f[dsof_pkg::BIT_DEVIATION];
            dsof_pkg::DSOF_OPT_ALARM: route = f[dsof_pkg::BIT_ALARM];
            default: route = 1'b0;
        endcase
    endfunction

    // one cycle after the flag, so pins follow inputs by two edges
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            oc_out11_n <= 1'b1;
            oc_out12_n <= 1'b1;
            relay_coil_on <= 1'b0;
        end else begin
            oc_out11_n <= ~route(sel_out11, flags); // R04 R14
            oc_out12_n <= ~route(sel_out12, flags); // R04 R14
            relay_coil_on <= route(sel_relay, flags); // R12 R14
        end
    end

    // ----------------------------------------------------------------
    // interrupts: rising flag edges, sticky, cleared by read
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags_d <= 3'h0;
            irq_status <= 3'h0;
            irq <= 1'b0;
        end else begin
            flags_d <= flags;
            // only bits actually returned are cleared; a new edge always wins
            irq_status <= (irq_status & ~(rd_go ? rd_snap : 3'h0)) | (flags & ~flags_d);
            irq <= |(irq_status & irq_mask);
        end
    end

endmodule // dsof_flags

// ### dsof_flags_properties.sv
/* Checker for dsof_flags: flag-to-pin timing, boundary hold and bus wait.
   Assumes full byte lanes on every register write. */
`timescale 1ns/1ns
module dsof_flags_properties #(
    parameter int LEVEL_W = 16
) (
    input wire logic clk_sys, // clock
    input wire logic rst, // reset
    input wire logic [LEVEL_W-1:0] output_current, // current
    input wire logic [LEVEL_W-1:0] loop_setpoint, // target
    input wire logic [LEVEL_W-1:0] process_value, // measured
    input wire logic trip_active, // trip
    input wire logic [4:0] avs_address, // address
    input wire logic avs_read, // read
    input wire logic avs_write, // write
    input wire logic [31:0] avs_writedata, // write data
    input wire logic avs_waitrequest, // stall
    input wire logic oc_out11_n, // pin 11
    input wire logic oc_out12_n, // pin 12
    input wire logic relay_coil_on // relay
);
    // ----------------------------------------------------------------
    // shadow of levels and selects
    // ----------------------------------------------------------------
    logic [LEVEL_W-1:0] ovl, dev, err;
    logic [7:0] s11, s12, sr;
    assign err = loop_setpoint > process_value ? loop_setpoint - process_value
                                                : process_value - loop_setpoint;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ovl <= dsof_pkg::RST_OVERLOAD_LEVEL;
            dev <= dsof_pkg::RST_DEVIATION_LEVEL;
            s11 <= 8'h03;
            s12 <= 8'h04;
            sr <= 8'h05;
        end else if (avs_write && !avs_waitrequest) begin
            case (avs_address)
                dsof_pkg::ADDR_OVERLOAD_LEVEL: ovl <= avs_writedata[LEVEL_W-1:0];
                dsof_pkg::ADDR_DEVIATION_LEVEL: dev <= avs_writedata[LEVEL_W-1:0];
                dsof_pkg::ADDR_SEL_OUT11: s11 <= avs_writedata[7:0];
                dsof_pkg::ADDR_SEL_OUT12: s12 <= avs_writedata[7:0];
                dsof_pkg::ADDR_SEL_RELAY: sr <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_ovl_set_low: assert property (output_current > ovl |-> ##2
        ($past(s11) != 8'h03 || !oc_out11_n)) else $error("overload pin not on");
    a_ovl_clear: assert property (output_current < ovl |-> ##2
        ($past(s11) != 8'h03 || oc_out11_n)) else $error("overload pin not off");
    a_dev_set: assert property (err > dev |-> ##2
        ($past(s12) != 8'h04 || !oc_out12_n)) else $error("deviation pin not on");
    a_dev_clear: assert property (err < dev |-> ##2
        ($past(s12) != 8'h04 || oc_out12_n)) else $error("deviation pin not off");
    a_alarm_relay: assert property (trip_active |-> ##2
        ($past(sr) != 8'h05 || relay_coil_on)) else $error("relay not on in trip");
    a_alarm_drop: assert property (!trip_active |-> ##2
        ($past(sr) != 8'h05 || !relay_coil_on)) else $error("relay on without trip");
    a_equal_hold: assert property ((output_current == ovl && s11 == 8'h03)
        ##1 s11 == 8'h03 |=> $stable(oc_out11_n)) else $error("pin moved at boundary");
    a_wait_ends: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("request not answered in one cycle");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    c_ovl: cover property (output_current > ovl ##2 !oc_out11_n);
    c_dev: cover property (err > dev ##2 !oc_out12_n);
    c_trip: cover property (trip_active ##2 relay_coil_on);
endmodule // dsof_flags_properties

bind dsof_flags dsof_flags_properties #(.LEVEL_W(LEVEL_W)) u_props (.clk_sys, .rst,
    .output_current, .loop_setpoint, .process_value, .trip_active, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_waitrequest, .oc_out11_n, .oc_out12_n, .relay_coil_on);

// ### dsof_load.sv
/* Loads on the output terminals: coils on the open collectors, relay contact.
   Assumes a pull-up on each open-collector terminal. */
`timescale 1ns/1ns
module dsof_load (
    input wire logic oc_out11_n, // pin 11
    input wire logic oc_out12_n, // pin 12
    input wire logic relay_coil_on, // relay coil
    output logic load11_on, // coil on pin 11 energised
    output logic load12_on, // coil on pin 12 energised
    output logic contact_a_closed // relay contact a
);
    // coil energised only while the transistor sinks current
    assign load11_on = !oc_out11_n;
    assign load12_on = !oc_out12_n;
    assign contact_a_closed = relay_coil_on;
endmodule // dsof_load

// ### dsof_flags_tb.sv
/* Self-checking bench for dsof_flags with a behavioural flag model.
   Assumes one wait cycle per bus access, pins settled two edges after inputs. */
`timescale 1ns/1ns
module dsof_flags_tb;
    // ----------------------------------------------------------------
    // signals and model state
    // ----------------------------------------------------------------
    logic clk_sys = 0, rst = 1, regen_braking = 0, trip_active = 0, avs_read = 0, avs_write = 0;
    logic [15:0] output_current = 0, loop_setpoint = 0, process_value = 0;
    logic [4:0] avs_address = 0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 0, avs_readdata, q, rs = 32'h02B74004;
    logic avs_waitrequest, oc_out11_n, oc_out12_n, relay_coil_on, irq, l11, l12, ca;
    int miscompares = 0, num_checks = 0, fl[3], lv[2], sel[3], st, mask, cur, sp, pv, t;
    logic [31:0] er[8] = '{32'h03E8, 32'h001E, 32'h03, 32'h04, 32'h05, 32'h0, 32'h0, 32'h0};
    int codes[4] = '{3, 4, 5, 7};
    always #50 clk_sys = ~clk_sys;
    dsof_flags dut (.clk_sys, .rst, .output_current, .regen_braking, .loop_setpoint,
        .process_value, .trip_active, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .oc_out11_n, .oc_out12_n,
        .relay_coil_on, .irq);
    dsof_load u_load (.oc_out11_n, .oc_out12_n, .relay_coil_on, .load11_on(l11),
        .load12_on(l12), .contact_a_closed(ca));
    function logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    function int fsel(int c);
        return c == 3 ? fl[0] : c == 4 ? fl[1] : c == 5 ? fl[2] : 0;
    endfunction
    task chk(string n, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task bus(logic w, logic [4:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            miscompares++;
            report_and_stop();
        end
        q = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
    endtask
    task rdchk(string n, logic [4:0] a, logic [31:0] e);
        bus(0, a, 0);
        chk(n, e, q);
    endtask
    // equal value holds; alarm compared as 2*trip against 1
    task upd();
        int v[3], l[3], p;
        v = '{cur, sp > pv ? sp - pv : pv - sp, 2 * t};
        l = '{lv[0], lv[1], 1};
        for (int i = 0; i < 3; i++) begin
            p = fl[i];
            if (v[i] > l[i]) fl[i] = 1;
            else if (v[i] < l[i]) fl[i] = 0;
            if (fl[i] && !p) st |= 1 << i;
        end
    endtask
    task report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        report_and_stop();
    end
    // ----------------------------------------------------------------
    // stimulus
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] r;
        lv = '{1000, 30};
        sel = '{3, 4, 5};
        repeat (3) @(posedge clk_sys);
        rst <= 0;
        for (int i = 0; i < 8; i++) rdchk("reset_value", 5'(i * 4), er[i]);
        rdchk("unmapped", 5'h02, 32'h0);
        for (int k = 0; k < 60; k++) begin
            r = rnd();
            lv = '{32'h0300 + r[7:0], r[13:8]};
            bus(1, dsof_pkg::ADDR_OVERLOAD_LEVEL, lv[0]);
            bus(1, dsof_pkg::ADDR_DEVIATION_LEVEL, lv[1]);
            for (int i = 0; i < 3 && k >= 8; i++) begin
                sel[i] = codes[rnd() % 4];
                bus(1, 5'(8 + 4 * i), sel[i]);
            end
            mask = rnd() % 8;
            bus(1, dsof_pkg::ADDR_IRQ_MASK, mask);
            upd();
            r = rnd();
            cur = lv[0] + int'(r[1:0]) - 2;
            sp = 100 + int'(r[9:2]);
            pv = r[10] ? sp + lv[1] + int'(r[12:11]) - 1 : sp - (lv[1] + int'(r[12:11]) - 1);
            t = r[14] & r[15];
            output_current <= 16'(cur);
            loop_setpoint <= 16'(sp);
            process_value <= 16'(pv);
            regen_braking <= r[13];
            trip_active <= 1'(t);
            repeat (4) @(posedge clk_sys);
            upd();
            chk("load11", fsel(sel[0]), l11);
            chk("load12", fsel(sel[1]), l12);
            chk("relay", fsel(sel[2]), ca);
            chk("irq", (st & mask) != 0, irq);
            rdchk("flag_state", dsof_pkg::ADDR_FLAG_STATE, fl[0] | fl[1] << 1 | fl[2] << 2);
            rdchk("irq_status", dsof_pkg::ADDR_IRQ_STATUS, st);
            st = 0;
        end
        report_and_stop();
    end
endmodule // dsof_flags_tb
